// ===== rtl/alarm_pkg.sv
// package: alarm codes, groups, limits and timing
package alarm_pkg;
  // number of fault sources, one flag bit each
  localparam int unsigned NUM_FAULTS = 12;
  // fault source bit positions
  localparam int unsigned F_OVERHEAT    = 0;
  localparam int unsigned F_OVERLOAD    = 1;
  localparam int unsigned F_OVERSPEED   = 2;
  localparam int unsigned F_PULSE_RATE  = 3;
  localparam int unsigned F_DEV_CUR_ON  = 4;
  localparam int unsigned F_DEV_CUR_OFF = 5;
  localparam int unsigned F_OP_DATA     = 6;
  localparam int unsigned F_GEAR_SET    = 7;
  localparam int unsigned F_SENSOR_RUN  = 8;
  localparam int unsigned F_SENSOR_INIT = 9;
  localparam int unsigned F_ROTOR_INIT  = 10;
  localparam int unsigned F_MOTOR_MIX   = 11;

  // decimal alarm codes as shown to a support tool
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_OVERHEAT  = 8'h15; // 21
  localparam logic [7:0] CODE_OVERLOAD  = 8'h1E; // 30
  localparam logic [7:0] CODE_OVERSPEED = 8'h1F; // 31
  localparam logic [7:0] CODE_PULSE     = 8'h22; // 34
  localparam logic [7:0] CODE_DEV_ON    = 8'h0A; // 10
  localparam logic [7:0] CODE_DEV_OFF   = 8'h0C; // 12
  localparam logic [7:0] CODE_OP_DATA   = 8'h46; // 70
  localparam logic [7:0] CODE_GEAR      = 8'h47; // 71
  localparam logic [7:0] CODE_SENS_RUN  = 8'h1C; // 28
  localparam logic [7:0] CODE_SENS_INIT = 8'h2A; // 42
  localparam logic [7:0] CODE_ROTOR     = 8'h2B; // 43
  localparam logic [7:0] CODE_MOTOR_MIX = 8'h2D; // 45

  // blink counts per group
  localparam logic [3:0] BLINK_TWO   = 4'h2;
  localparam logic [3:0] BLINK_FOUR  = 4'h4;
  localparam logic [3:0] BLINK_SEVEN = 4'h7;
  localparam logic [3:0] BLINK_EIGHT = 4'h8;

  // three-bit code outputs per group, bit2..bit0
  localparam logic [2:0] GRP_CODE_TWO   = 3'h2;
  localparam logic [2:0] GRP_CODE_FOUR  = 3'h4;
  localparam logic [2:0] GRP_CODE_SEVEN = 3'h7;
  localparam logic [2:0] GRP_CODE_EIGHT = 3'h0;

  // masks over the fault bits
  localparam logic [11:0] MASK_LOCKED   = 12'hF00; // sensor and motor faults: power cycle only
  localparam logic [11:0] MASK_KEEP_CUR = 12'h040; // operation data fault keeps current

  // thresholds
  localparam logic [7:0]  TEMP_LIMIT_C    = 8'h55;   // 85 degC
  localparam logic [15:0] SPEED_LIMIT_RPM = 16'h1194; // 4500 r/min
  localparam int unsigned PULSE_LIMIT_KHZ = 500;

  // history depth
  localparam int unsigned HIST_DEPTH = 10;

  // timing at the 10 MHz clock
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned BLINK_ON_MS  = 200;
  localparam int unsigned BLINK_OFF_MS = 200;
  localparam int unsigned BLINK_GAP_MS = 1000;
  localparam int unsigned BLINK_ON_CYC  = CLK_HZ / 1000 * BLINK_ON_MS;
  localparam int unsigned BLINK_OFF_CYC = CLK_HZ / 1000 * BLINK_OFF_MS;
  localparam int unsigned BLINK_GAP_CYC = CLK_HZ / 1000 * BLINK_GAP_MS;
  // pulse rate gate: one millisecond window, limit counted per window
  localparam int unsigned RATE_WIN_MS   = 1;
  localparam int unsigned RATE_WIN_CYC  = CLK_HZ / 1000 * RATE_WIN_MS;
  localparam int unsigned RATE_MAX_CNT  = PULSE_LIMIT_KHZ * RATE_WIN_MS;
endpackage

// ===== rtl/blink_driver.sv
// module: indicator burst of count blinks, then a pause
`timescale 1ns/1ps
module blink_driver #(
  parameter int unsigned ON_CYC  = alarm_pkg::BLINK_ON_CYC,
  parameter int unsigned OFF_CYC = alarm_pkg::BLINK_OFF_CYC,
  parameter int unsigned GAP_CYC = alarm_pkg::BLINK_GAP_CYC
) (
  input  wire logic       clock,     // system clock
  input  wire logic       sys_rst,   // async reset, active high
  input  wire logic       run,       // blink while high
  input  wire logic [3:0] count,     // blinks per burst
  output logic            led_r      // indicator drive
);
  typedef enum logic [1:0] {IDLE, LIT, DARK, GAP} blink_state_type;

  blink_state_type state_r;
  logic [31:0]     timer_r;
  logic [3:0]      done_r;

  wire timer_done = (timer_r == 32'h00000000);

  // timer paces each phase; run low returns to idle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= IDLE;
      timer_r <= 32'h00000000;
      done_r  <= 4'h0;
      led_r   <= 1'b0;
    end else if (!run) begin
      state_r <= IDLE;
      led_r   <= 1'b0;
    end else if (state_r == IDLE) begin
      state_r <= LIT;
      timer_r <= 32'(ON_CYC - 1);
      done_r  <= 4'h0;
      led_r   <= 1'b1;
    end else if (!timer_done) begin
      timer_r <= timer_r - 32'h00000001;
    end else begin
      case (state_r)
        LIT: begin
          done_r <= done_r + 4'h1;
          led_r  <= 1'b0;
          if (done_r + 4'h1 >= count) begin
            state_r <= GAP;
            timer_r <= 32'(GAP_CYC - 1);
          end else begin
            state_r <= DARK;
            timer_r <= 32'(OFF_CYC - 1);
          end
        end
        DARK: begin
          state_r <= LIT;
          led_r   <= 1'b1;
          timer_r <= 32'(ON_CYC - 1);
        end
        default: begin
          state_r <= LIT;
          done_r  <= 4'h0;
          led_r   <= 1'b1;
          timer_r <= 32'(ON_CYC - 1);
        end
      endcase
    end
  end
endmodule // blink_driver

// ===== rtl/drive_alarm_handler.sv
// module: alarm detect, latch, code, blink and history
//
// Notes on behaviour
// R1: any alarm drops alarm output; all but operation data alarm stop motor
// R2: operation data alarm keeps motor running
// R3: enable repurposes ready, torque, timing as code
// R4: indicator blinks group count while alarmed
// R5: ten newest alarms kept, readable and clearable
// R6: alarm cleared on falling edge of clear input
// R7: tool reset command also clears alarms
// R8: sensor and motor alarms survive clear input and tool reset; only a power cycle clears them
// R9: overheat above 85 degC, two blinks
// R10: overload when accumulated load reaches threshold
// R11: overspeed above 4500 r/min unless geared
// R12: pulse rate above limit raises alarm
// R13: deviation alarms: four blinks, code 100
// R14: data and gear alarms: seven blinks, 111
// R15: sensor and motor alarms: eight, 000
// R16: current-removing alarms cut motor current
// R17: current-keeping alarms keep motor current
// R18: current-on deviation beyond overflow limit alarms
// R19: current-on during off-deviation warning alarms
// R20: alarm stays latched until valid reset
`timescale 1ns/1ps
module drive_alarm_handler #(
  parameter int unsigned BLINK_ON_CYC  = alarm_pkg::BLINK_ON_CYC,
  parameter int unsigned BLINK_OFF_CYC = alarm_pkg::BLINK_OFF_CYC,
  parameter int unsigned BLINK_GAP_CYC = alarm_pkg::BLINK_GAP_CYC,
  parameter int unsigned RATE_WIN_CYC  = alarm_pkg::RATE_WIN_CYC
) (
  input  wire logic        clock,                    // 10 MHz system clock
  input  wire logic        sys_rst,                  // async reset, power cycle
  input  wire logic [7:0]  temperature_c,            // internal temperature, degC
  input  wire logic [15:0] load_accum,               // load above peak torque, accumulated
  input  wire logic [15:0] overload_threshold,       // overload threshold setting
  input  wire logic [15:0] shaft_speed_rpm,          // output shaft speed
  input  wire logic        geared_motor,             // high for geared motors
  input  wire logic        cmd_pulse,                // one-cycle command pulse strobe
  input  wire logic        current_on,               // motor current on input
  input  wire logic [31:0] position_error,           // |commanded - actual| position
  input  wire logic [31:0] overflow_rotation_limit,  // deviation limit setting
  input  wire logic        dev_off_warning,          // current-off deviation warning
  input  wire logic        op_data_fault,            // abnormal operation data detect
  input  wire logic        gear_fault,               // gear setting out of range
  input  wire logic        sensor_run_fault,         // sensor fault while running
  input  wire logic        sensor_init_fault,        // sensor fault at power on
  input  wire logic        rotor_init_fault,         // rotor turned during init
  input  wire logic        motor_mix_fault,          // unsupported motor
  input  wire logic        fault_clear_in,           // alarm reset input, level
  input  wire logic        tool_reset,               // support tool reset, pulse
  input  wire logic        fault_code_output_enable, // code on ready/torque/timing
  input  wire logic        ready_in,                 // normal ready level
  input  wire logic        torque_limit_in,          // normal torque-limit level
  input  wire logic        timing_in,                // normal timing level
  input  wire logic [3:0]  hist_index,               // history slot, 0 newest
  input  wire logic        hist_clear,               // support tool clears history
  output logic             alarm_out,                // high when no alarm
  output logic             motor_current_en,         // motor current allowed
  output logic             motor_run_en,             // motor may run
  output logic             ready_out,                // ready or fault_code_bit0
  output logic             torque_limit_out,         // torque limit or fault_code_bit1
  output logic             timing_out,               // timing or fault_code_bit2
  output logic             alarm_led,                // blink indicator
  output logic [7:0]       alarm_code_r,             // present alarm code
  output logic [7:0]       hist_code_r,              // history entry at hist_index
  output logic [3:0]       hist_count_r              // valid history entries
);
  localparam int unsigned NF = alarm_pkg::NUM_FAULTS;

  // fault detection
  logic [15:0] rate_cnt_r;
  logic [31:0] win_cnt_r;
  logic        rate_over_r;
  wire         win_end = (win_cnt_r == 32'(RATE_WIN_CYC - 1));

  // a count per window needs no period measure
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      win_cnt_r   <= 32'h00000000;
      rate_cnt_r  <= 16'h0000;
      rate_over_r <= 1'b0;
    end else begin
      win_cnt_r   <= win_end ? 32'h00000000 : win_cnt_r + 32'h00000001;
      rate_cnt_r  <= win_end ? 16'h0000 : rate_cnt_r + {15'h0000, cmd_pulse};
      rate_over_r <= (rate_cnt_r > 16'(alarm_pkg::RATE_MAX_CNT)); // R12
    end
  end

  logic [NF-1:0] cause;
  assign cause[alarm_pkg::F_OVERHEAT]    = temperature_c > alarm_pkg::TEMP_LIMIT_C; // R9
  assign cause[alarm_pkg::F_OVERLOAD]    = load_accum >= overload_threshold; // R10
  assign cause[alarm_pkg::F_OVERSPEED]   = !geared_motor &&
                                           (shaft_speed_rpm > alarm_pkg::SPEED_LIMIT_RPM); // R11
  assign cause[alarm_pkg::F_PULSE_RATE]  = rate_over_r; // R12
  assign cause[alarm_pkg::F_DEV_CUR_ON]  = current_on &&
                                           (position_error > overflow_rotation_limit); // R18
  assign cause[alarm_pkg::F_DEV_CUR_OFF] = current_on && dev_off_warning; // R19
  assign cause[alarm_pkg::F_OP_DATA]     = op_data_fault;
  assign cause[alarm_pkg::F_GEAR_SET]    = gear_fault;
  assign cause[alarm_pkg::F_SENSOR_RUN]  = sensor_run_fault;
  assign cause[alarm_pkg::F_SENSOR_INIT] = sensor_init_fault;
  assign cause[alarm_pkg::F_ROTOR_INIT]  = rotor_init_fault;
  assign cause[alarm_pkg::F_MOTOR_MIX]   = motor_mix_fault;

  // reset events
  logic clear_in_d_r;
  wire  clear_fall = clear_in_d_r && !fault_clear_in; // R6
  wire  clear_evt  = clear_fall || tool_reset; // R7

  // latched alarm flags
  logic [NF-1:0] latch_r;
  logic [NF-1:0] latch_nxt;

  // set wins over clear; locked faults ignore clears
  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_flag
      wire locked = alarm_pkg::MASK_LOCKED[g];
      assign latch_nxt[g] = cause[g] ||
                            (latch_r[g] && !(clear_evt && !locked)); // R8 R20
    end
  endgenerate

  wire any_alarm   = |latch_r;
  wire cut_current = |(latch_r & ~alarm_pkg::MASK_KEEP_CUR); // R16

  // first alarm selection: lowest bit wins
  logic [7:0] code_sel;
  logic [3:0] blink_sel;
  logic [2:0] grp_sel;
  always_comb begin
    code_sel  = alarm_pkg::CODE_NONE;
    blink_sel = 4'h0;
    grp_sel   = 3'h0;
    if (latch_r[alarm_pkg::F_OVERHEAT]) begin
      code_sel = alarm_pkg::CODE_OVERHEAT;
    end else if (latch_r[alarm_pkg::F_OVERLOAD]) begin
      code_sel = alarm_pkg::CODE_OVERLOAD;
    end else if (latch_r[alarm_pkg::F_OVERSPEED]) begin
      code_sel = alarm_pkg::CODE_OVERSPEED;
    end else if (latch_r[alarm_pkg::F_PULSE_RATE]) begin
      code_sel = alarm_pkg::CODE_PULSE;
    end else if (latch_r[alarm_pkg::F_DEV_CUR_ON]) begin
      code_sel = alarm_pkg::CODE_DEV_ON;
    end else if (latch_r[alarm_pkg::F_DEV_CUR_OFF]) begin
      code_sel = alarm_pkg::CODE_DEV_OFF;
    end else if (latch_r[alarm_pkg::F_OP_DATA]) begin
      code_sel = alarm_pkg::CODE_OP_DATA;
    end else if (latch_r[alarm_pkg::F_GEAR_SET]) begin
      code_sel = alarm_pkg::CODE_GEAR;
    end else if (latch_r[alarm_pkg::F_SENSOR_RUN]) begin
      code_sel = alarm_pkg::CODE_SENS_RUN;
    end else if (latch_r[alarm_pkg::F_SENSOR_INIT]) begin
      code_sel = alarm_pkg::CODE_SENS_INIT;
    end else if (latch_r[alarm_pkg::F_ROTOR_INIT]) begin
      code_sel = alarm_pkg::CODE_ROTOR;
    end else if (latch_r[alarm_pkg::F_MOTOR_MIX]) begin
      code_sel = alarm_pkg::CODE_MOTOR_MIX;
    end
    // group of the shown alarm picks blinks and code bits
    if (|latch_r[alarm_pkg::F_PULSE_RATE:alarm_pkg::F_OVERHEAT]) begin
      blink_sel = alarm_pkg::BLINK_TWO; // R9
      grp_sel   = alarm_pkg::GRP_CODE_TWO; // R9
    end else if (|latch_r[alarm_pkg::F_DEV_CUR_OFF:alarm_pkg::F_DEV_CUR_ON]) begin
      blink_sel = alarm_pkg::BLINK_FOUR; // R13
      grp_sel   = alarm_pkg::GRP_CODE_FOUR; // R13
    end else if (|latch_r[alarm_pkg::F_GEAR_SET:alarm_pkg::F_OP_DATA]) begin
      blink_sel = alarm_pkg::BLINK_SEVEN; // R14
      grp_sel   = alarm_pkg::GRP_CODE_SEVEN; // R14
    end else if (any_alarm) begin
      blink_sel = alarm_pkg::BLINK_EIGHT; // R15
      grp_sel   = alarm_pkg::GRP_CODE_EIGHT; // R15
    end
  end

  // history: shift in on each newly shown alarm code
  logic [7:0] hist_mem [alarm_pkg::HIST_DEPTH];
  logic [7:0] last_code_r;
  wire        hist_push = (code_sel != alarm_pkg::CODE_NONE) && (code_sel != last_code_r);

  // a latched alarm logs each time it becomes the shown code
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < alarm_pkg::HIST_DEPTH; i++) begin
        hist_mem[i] <= 8'h00;
      end
      hist_count_r <= 4'h0;
    end else if (hist_push) begin
      hist_mem[0] <= code_sel; // R5
      for (int i = 1; i < alarm_pkg::HIST_DEPTH; i++) begin
        hist_mem[i] <= hist_mem[i-1];
      end
      if (hist_count_r != 4'(alarm_pkg::HIST_DEPTH)) begin
        hist_count_r <= hist_count_r + 4'h1;
      end
    end else if (hist_clear) begin
      hist_count_r <= 4'h0; // R5
    end
  end

  wire hist_valid = (hist_index < hist_count_r);

  // registered outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clear_in_d_r     <= 1'b0;
      latch_r          <= '0;
      last_code_r      <= 8'h00;
      alarm_code_r     <= 8'h00;
      hist_code_r      <= 8'h00;
      alarm_out        <= 1'b0;
      motor_current_en <= 1'b0;
      motor_run_en     <= 1'b0;
      ready_out        <= 1'b0;
      torque_limit_out <= 1'b0;
      timing_out       <= 1'b0;
    end else begin
      clear_in_d_r     <= fault_clear_in;
      latch_r          <= latch_nxt; // R20
      last_code_r      <= code_sel;
      alarm_code_r     <= code_sel;
      hist_code_r      <= hist_valid ? hist_mem[hist_index] : 8'h00;
      alarm_out        <= !any_alarm; // R1
      motor_current_en <= !cut_current; // R16 R17
      motor_run_en     <= !cut_current; // R1 R2
      ready_out        <= fault_code_output_enable ? grp_sel[0] : ready_in; // R3
      torque_limit_out <= fault_code_output_enable ? grp_sel[1] : torque_limit_in; // R3
      timing_out       <= fault_code_output_enable ? grp_sel[2] : timing_in; // R3
    end
  end

  // indicator
  blink_driver #(
    .ON_CYC  (BLINK_ON_CYC),
    .OFF_CYC (BLINK_OFF_CYC),
    .GAP_CYC (BLINK_GAP_CYC)
  ) u_blink (
    .clock   (clock),
    .sys_rst (sys_rst),
    .run     (any_alarm), // R4
    .count   (blink_sel),
    .led_r   (alarm_led)
  );
endmodule // drive_alarm_handler

// ===== bench/host_model.sv
// host model: clear input on then off, command pulse train
`timescale 1ns/1ps
module host_model (
  input  wire logic        clock,          // system clock
  input  wire logic        sys_rst,        // power cycle
  input  wire logic        clear_req,      // bench asks for one clear
  input  wire logic [15:0] pulse_gap,      // cycles between pulses, 0 stops
  output logic             fault_clear_in, // alarm reset input
  output logic             cmd_pulse       // one-cycle command pulse
);
  logic [1:0]  hold_r;
  logic [15:0] gap_r;
  // clear held on two cycles, then off: one clean off edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r         <= 2'h0;
      fault_clear_in <= 1'b0;
    end else if (clear_req) begin
      hold_r         <= 2'h2;
      fault_clear_in <= 1'b1;
    end else if (hold_r != 2'h0) begin
      hold_r         <= hold_r - 2'h1;
      fault_clear_in <= (hold_r != 2'h1);
    end
  end
  // bench sets the rate; legal runs stay under the limit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r     <= 16'h0000;
      cmd_pulse <= 1'b0;
    end else begin
      cmd_pulse <= (pulse_gap != 16'h0000) && (gap_r <= 16'h0001);
      gap_r     <= (gap_r <= 16'h0001) ? pulse_gap : gap_r - 16'h0001;
    end
  end
endmodule // host_model

// ===== bench/alarm_handler_sva.sv
// checker: alarm handler port relations
`timescale 1ns/1ps
module alarm_handler_chk (
  input wire logic        clock,                    // system clock
  input wire logic        sys_rst,                  // power cycle
  input wire logic [7:0]  temperature_c,            // temperature
  input wire logic [15:0] shaft_speed_rpm,          // shaft speed
  input wire logic        geared_motor,             // geared flag
  input wire logic        fault_clear_in,           // clear input
  input wire logic        tool_reset,               // tool clear
  input wire logic        fault_code_output_enable, // code enable
  input wire logic        ready_in,                 // ready level
  input wire logic        alarm_out,                // high when clear
  input wire logic        motor_current_en,         // current allowed
  input wire logic        motor_run_en,             // run allowed
  input wire logic        ready_out,                // code bit0
  input wire logic        torque_limit_out,         // code bit1
  input wire logic        timing_out,               // code bit2
  input wire logic        alarm_led,                // indicator
  input wire logic [7:0]  alarm_code_r,             // shown code
  input wire logic [3:0]  hist_count_r              // history count
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // group code for a shown alarm code, bit2..bit0
  function automatic logic [2:0] grp(logic [7:0] c);
    case (c)
      8'h15, 8'h1E, 8'h1F, 8'h22: return 3'h2;
      8'h0A, 8'h0C:               return 3'h4;
      8'h46, 8'h47:               return 3'h7;
      default:                    return 3'h0;
    endcase
  endfunction
  a_overheat_raise: assert property (temperature_c > 8'h55 |-> ##2 !alarm_out)
    else $error("overheat left alarm output high");
  a_overspeed_raise: assert property (shaft_speed_rpm > 16'h1194 && !geared_motor |-> ##2 !alarm_out)
    else $error("overspeed left alarm output high");
  // first edge after reset shows reset values: skipped
  a_code_matches_out: assert property (!$past(sys_rst) |-> (alarm_code_r != 8'h00) == !alarm_out)
    else $error("alarm code and alarm output disagree");
  a_cut_current: assert property (alarm_code_r != 8'h00 && alarm_code_r != 8'h46 |-> !motor_current_en && !motor_run_en)
    else $error("current kept on a current-removing alarm");
  a_keep_current: assert property (!alarm_out && motor_current_en |-> alarm_code_r == 8'h46 && motor_run_en)
    else $error("current kept on a wrong alarm");
  a_code_outputs: assert property (!$past(sys_rst) && $past(fault_code_output_enable) && alarm_code_r != 8'h00 |-> {timing_out, torque_limit_out, ready_out} == grp(alarm_code_r))
    else $error("group code outputs wrong");
  a_pass_through: assert property (!$past(sys_rst) && !$past(fault_code_output_enable) |-> ready_out == $past(ready_in))
    else $error("ready level not passed through");
  a_locked_hold: assert property (alarm_code_r inside {8'h1C, 8'h2A, 8'h2B, 8'h2D} |=> !alarm_out)
    else $error("locked alarm was cleared");
  a_clear_cause: assert property ($rose(alarm_out) && !$past(sys_rst, 2) |-> $past(tool_reset, 2) || ($past(fault_clear_in, 3) && !$past(fault_clear_in, 2)))
    else $error("alarm released without a clear");
  a_led_quiet: assert property (alarm_out && $past(alarm_out) && $past(alarm_out, 2) |-> !alarm_led)
    else $error("indicator lit without alarm");
  a_hist_bound: assert property (hist_count_r <= 4'hA)
    else $error("history count above ten");
  c_op_data: cover property (alarm_code_r == 8'h46);
  c_pulse_rate: cover property (alarm_code_r == 8'h22);
  c_locked: cover property (alarm_code_r == 8'h2D);
  c_hist_full: cover property (hist_count_r == 4'hA);
endmodule // alarm_handler_chk

bind drive_alarm_handler alarm_handler_chk u_chk (
  .clock, .sys_rst, .temperature_c, .shaft_speed_rpm, .geared_motor, .fault_clear_in,
  .tool_reset, .fault_code_output_enable, .ready_in, .alarm_out, .motor_current_en,
  .motor_run_en, .ready_out, .torque_limit_out, .timing_out, .alarm_led, .alarm_code_r,
  .hist_count_r
);

// ===== bench/tb_drive_alarm_handler.sv
// testbench: faults, clears, blinks, history, pass-through
`timescale 1ns/1ps
module tb_drive_alarm_handler;
  logic        clock, sys_rst, geared_motor, current_on, dev_off_warning, op_data_fault;
  logic        gear_fault, sensor_run_fault, sensor_init_fault, rotor_init_fault;
  logic        motor_mix_fault, tool_reset, fault_code_output_enable, ready_in;
  logic        torque_limit_in, timing_in, hist_clear, clear_req, fault_clear_in, cmd_pulse;
  logic        alarm_out, motor_current_en, motor_run_en, ready_out, torque_limit_out;
  logic        timing_out, alarm_led, prev;
  logic [7:0]  temperature_c, alarm_code_r, hist_code_r;
  logic [15:0] load_accum, overload_threshold, shaft_speed_rpm, pulse_gap;
  logic [31:0] position_error, overflow_rotation_limit;
  logic [3:0]  hist_index, hist_count_r;
  int          n_errors, num_checks, seed, k, f, j, rises;
  localparam logic [7:0] EXP_CODE [12] = '{8'h15, 8'h1E, 8'h1F, 8'h22, 8'h0A, 8'h0C,
                                          8'h46, 8'h47, 8'h1C, 8'h2A, 8'h2B, 8'h2D};
  localparam logic [2:0] EXP_GRP [12] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h4,
                                         3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0};

  // blink count per alarm group
  function automatic int exp_blink(int i);
    return (i < 4) ? 2 : (i < 6) ? 4 : (i < 8) ? 7 : 8;
  endfunction

  // short blink timing keeps one burst to tens of cycles
  drive_alarm_handler #(.BLINK_ON_CYC(4), .BLINK_OFF_CYC(4), .BLINK_GAP_CYC(10),
    .RATE_WIN_CYC(1200)) dut (
    .clock, .sys_rst, .temperature_c, .load_accum, .overload_threshold, .shaft_speed_rpm,
    .geared_motor, .cmd_pulse, .current_on, .position_error, .overflow_rotation_limit,
    .dev_off_warning, .op_data_fault, .gear_fault, .sensor_run_fault, .sensor_init_fault,
    .rotor_init_fault, .motor_mix_fault, .fault_clear_in, .tool_reset,
    .fault_code_output_enable, .ready_in, .torque_limit_in, .timing_in, .hist_index,
    .hist_clear, .alarm_out, .motor_current_en, .motor_run_en, .ready_out,
    .torque_limit_out, .timing_out, .alarm_led, .alarm_code_r, .hist_code_r, .hist_count_r);

  host_model host (.clock(clock), .sys_rst(sys_rst), .clear_req(clear_req),
    .pulse_gap(pulse_gap), .fault_clear_in(fault_clear_in), .cmd_pulse(cmd_pulse));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk1(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // off values sit on or just inside each limit: no alarm
  task automatic set_fault(int i, logic on);
    case (i)
      0: temperature_c <= on ? 8'h56 : 8'h55;
      1: load_accum <= on ? overload_threshold : overload_threshold - 16'h0001;
      2: shaft_speed_rpm <= on ? 16'h1195 : 16'h1194;
      3: pulse_gap <= on ? 16'h0002 : 16'h0003;
      4: position_error <= on ? overflow_rotation_limit + 32'h1 : overflow_rotation_limit;
      5: dev_off_warning <= on;
      6: op_data_fault <= on;
      7: gear_fault <= on;
      8: sensor_run_fault <= on;
      9: sensor_init_fault <= on;
      10: rotor_init_fault <= on;
      default: motor_mix_fault <= on;
    endcase
  endtask

  task automatic end_sim;
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40000 * 100);
    n_errors++;
    end_sim;
  end

  initial begin
    seed = 18802;
    {sys_rst, current_on} = 2'h3;
    {geared_motor, dev_off_warning, op_data_fault, gear_fault, sensor_run_fault} = 5'h00;
    {sensor_init_fault, rotor_init_fault, motor_mix_fault, tool_reset} = 4'h0;
    {fault_code_output_enable, ready_in, torque_limit_in, timing_in, hist_clear} = 5'h00;
    {clear_req, hist_index, pulse_gap} = 21'h00003;
    overload_threshold = 16'h0100 | 16'($random(seed));
    overflow_rotation_limit = 32'($random(seed)) & 32'h7FFF_FFFF;
    load_accum = overload_threshold - 16'h0001;
    position_error = overflow_rotation_limit;
    {temperature_c, shaft_speed_rpm} = {8'h55, 16'h1194};
    cyc(20);
    sys_rst <= 1'b0;
    // random normal levels pass through while code output is off
    for (j = 0; j < 8; j++) begin
      {timing_in, torque_limit_in, ready_in} <= 3'($random(seed));
      cyc(2);
      chk8({5'h00, timing_out, torque_limit_out, ready_out}, {5'h00, timing_in, torque_limit_in, ready_in});
    end
    geared_motor <= 1'b1;
    shaft_speed_rpm <= 16'h2328;
    cyc(4);
    chk1(alarm_out, 1'b1);
    {geared_motor, shaft_speed_rpm, fault_code_output_enable} <= {1'b0, 16'h1194, 1'b1};
    // two passes over resettable faults, then the locked ones
    for (k = 0; k < 20; k++) begin
      f = (k < 16) ? k % 8 : k - 8;
      set_fault(f, 1'b1);
      for (j = 0; j < ((f == 3) ? 3000 : 4) && alarm_out !== 1'b0; j++) @(posedge clock);
      cyc(1);
      chk8(alarm_code_r, EXP_CODE[f]);
      chk8({5'h00, timing_out, torque_limit_out, ready_out}, {5'h00, EXP_GRP[f]});
      chk1(motor_current_en, f == 6);
      chk1(motor_run_en, f == 6);
      rises = 0;
      prev = alarm_led;
      repeat (exp_blink(f) * 8 + 10) begin
        @(posedge clock);
        rises += int'(alarm_led && !prev);
        prev = alarm_led;
      end
      chk8(8'(rises), 8'(exp_blink(f)));
      set_fault(f, 1'b0);
      cyc((f == 3) ? 1300 : 3);
      chk1(alarm_out, 1'b0);
      if ((k + k / 8) % 2 == 0) clear_req <= 1'b1;
      else tool_reset <= 1'b1;
      cyc(1);
      {clear_req, tool_reset} <= 2'h0;
      cyc(8);
      chk1(alarm_out, f < 8);
      if (f >= 8) begin
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        cyc(3);
        chk1(alarm_out, 1'b1);
      end
      if (k == 15) begin
        chk8({4'h0, hist_count_r}, 8'h0A);
        for (j = 0; j < 3; j++) begin
          hist_index <= (j == 2) ? 4'h9 : 4'(j);
          cyc(2);
          chk8(hist_code_r, EXP_CODE[(j == 0) ? 7 : 6]);
        end
        {hist_index, hist_clear} <= 5'h01;
        cyc(1);
        hist_clear <= 1'b0;
        cyc(2);
        chk8({4'h0, hist_count_r}, 8'h00);
        chk8(hist_code_r, 8'h00);
      end
    end
    end_sim;
  end
endmodule // tb_drive_alarm_handler
